// ---- pin_select_pkg.sv ----
// shared constants and types for the control and audio pin selection
package pin_select_pkg;

	// system clock and the master clock range the device accepts
	localparam int CLOCK_HZ       = 40_000_000;
	localparam int MCLK_MIN_HZ    = 500_000;
	localparam int MCLK_MAX_HZ    = 30_000_000;
	localparam int MCLK_TARGET_HZ = 10_000_000;
	// half period of the divided master clock, rounded down, at least one
	localparam int MCLK_HALF_RAW  = CLOCK_HZ / (2 * MCLK_TARGET_HZ);
	localparam int MCLK_HALF_CYCLES = (MCLK_HALF_RAW < 1) ? 1 : MCLK_HALF_RAW;
	localparam int MCLK_CNT_W     = 8;

	// pin levels with a fixed meaning
	localparam logic SPI_SELECT_LEVEL = 1'b1;
	localparam logic TEST_ENTRY_LEVEL = 1'b1;
	localparam logic CS_ACTIVE_LEVEL  = 1'b0;
	localparam logic IDLE_HIGH        = 1'b1;

	// output enables are active low
	localparam logic DRIVE_ON  = 1'b0;
	localparam logic DRIVE_OFF = 1'b1;

	// number of general-purpose pins
	localparam int GPIO_PINS = 2;

	// control-port personality chosen by the strap and test pin
	typedef enum logic [1:0] {
		mode_wait,
		mode_i2c,
		mode_spi,
		mode_test
	} ctrl_mode_e;

	// turn a drive request into an active-low output enable
	function automatic logic drive_oen(input logic drive);
		drive_oen = drive ? DRIVE_ON : DRIVE_OFF;
	endfunction

endpackage

// ---- pin_select_if.sv ----
// pin bundle between the audio device and its host controller
`timescale 1ns/10ps
interface pin_select_if;
	import pin_select_pkg::*;

	// strap and shared select, driven by the host only
	logic                 ctrl_sel;
	logic                 test_cs;
	// control clock, host to device only
	logic                 ctrl_clk;
	// control data, open drain in one mode, host push in the other
	logic                 data_dev_o;
	logic                 data_dev_oen;
	logic                 data_host_o;
	logic                 data_host_oen;
	logic                 ctrl_data;
	// push-pull interrupt and serial audio data
	logic                 irq;
	logic                 audio_serial_out;
	logic                 audio_serial_in;
	// word select and bit clock, either side may drive
	logic                 ws_dev_o;
	logic                 ws_dev_oen;
	logic                 ws_host_o;
	logic                 ws_host_oen;
	logic                 ws;
	logic                 bclk_dev_o;
	logic                 bclk_dev_oen;
	logic                 bclk_host_o;
	logic                 bclk_host_oen;
	logic                 bclk;
	// general-purpose pins
	logic [GPIO_PINS-1:0] gpio_dev_o;
	logic [GPIO_PINS-1:0] gpio_dev_oen;
	logic [GPIO_PINS-1:0] gpio_host_o;
	logic [GPIO_PINS-1:0] gpio_host_oen;
	logic [GPIO_PINS-1:0] gpio;
	// master clock into the device
	logic                 mclk;

	// open drain with pull-up: any enabled low driver wins
	assign ctrl_data = (data_dev_oen  == DRIVE_ON ? data_dev_o  : IDLE_HIGH)
		& (data_host_oen == DRIVE_ON ? data_host_o : IDLE_HIGH);
	// cmos pins: device first, then host, else weak pull-down
	assign ws   = (ws_dev_oen == DRIVE_ON) ? ws_dev_o
		: (ws_host_oen == DRIVE_ON) ? ws_host_o : 1'b0;
	assign bclk = (bclk_dev_oen == DRIVE_ON) ? bclk_dev_o
		: (bclk_host_oen == DRIVE_ON) ? bclk_host_o : 1'b0;
	for (genvar g = 0; g < GPIO_PINS; g++)
	begin : g_gpio
		assign gpio[g] = (gpio_dev_oen[g] == DRIVE_ON) ? gpio_dev_o[g]
			: (gpio_host_oen[g] == DRIVE_ON) ? gpio_host_o[g] : 1'b0;
	end

	modport device_end (
		input  ctrl_sel, test_cs, ctrl_clk, ctrl_data,
		output data_dev_o, data_dev_oen,
		output irq, audio_serial_out,
		input  audio_serial_in,
		output ws_dev_o, ws_dev_oen, bclk_dev_o, bclk_dev_oen,
		input  ws, bclk,
		output gpio_dev_o, gpio_dev_oen,
		input  gpio, mclk
	);

	modport host_end (
		output ctrl_sel, test_cs, ctrl_clk,
		output data_host_o, data_host_oen,
		input  ctrl_data, irq, audio_serial_out,
		output audio_serial_in,
		output ws_host_o, ws_host_oen, bclk_host_o, bclk_host_oen,
		input  ws, bclk,
		output gpio_host_o, gpio_host_oen,
		input  gpio,
		output mclk
	);
endinterface

// ---- pin_select_device.sv ----
// device end: control port selection and digital pin directions
`timescale 1ns/10ps
// Contract
// (R1) strap high picks spi, low picks i2c
// (R2) in spi, shared pin is chip select
// (R3) i2c strap plus high shared pin: test
// (R4) host keeps shared pin low in i2c
// (R5) data pin: open-drain i2c, spi input
// (R6) clock pin is input in both modes
// (R7) interrupt output is push-pull, always driven
// (R8) word select driven as master, received as slave
// (R9) bit clock driven as master, received as slave
// (R10) cmos pin direction set by control setting
// (R11) host supplies master clock 0.5-30 mhz
// (R12) host holds strap fixed after power-up
module pin_select_device
	import pin_select_pkg::*;
(
	// clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_rstn,
	// pins toward the host
	pin_select_if.device_end          pins,
	// control-port core side
	input  wire logic                 i_i2c_data_low,
	output logic                      o_ctrl_spi,
	output logic                      o_test_mode,
	output logic                      o_spi_cs_active,
	output logic                      o_ctrl_sck,
	output logic                      o_ctrl_sdi,
	output logic                      o_i2c_sda_in,
	// interrupt and audio data
	input  wire logic                 i_irq_request,
	input  wire logic                 i_audio_serial_out,
	output logic                      o_audio_serial_in,
	// audio clocking, direction from a control setting
	input  wire logic                 i_audio_master,
	input  wire logic                 i_ws_out,
	input  wire logic                 i_bclk_out,
	output logic                      o_ws_in,
	output logic                      o_bclk_in,
	// general-purpose pins, direction from a control setting
	input  wire logic [GPIO_PINS-1:0] i_gpio_dir_out,
	input  wire logic [GPIO_PINS-1:0] i_gpio_out,
	output logic      [GPIO_PINS-1:0] o_gpio_in,
	// master clock as sampled at the system clock
	output logic                      o_mclk_level
);

	ctrl_mode_e           mode_reg;
	ctrl_mode_e           mode_next;
	logic                 spi_reg;
	logic                 test_reg;
	logic                 cs_reg;
	logic                 sck_reg;
	logic                 sdi_reg;
	logic                 sda_in_reg;
	logic                 data_oen_reg;
	logic                 irq_reg;
	logic                 ser_out_reg;
	logic                 ser_in_reg;
	logic                 ws_o_reg;
	logic                 ws_oen_reg;
	logic                 bclk_o_reg;
	logic                 bclk_oen_reg;
	logic                 ws_in_reg;
	logic                 bclk_in_reg;
	logic [GPIO_PINS-1:0] gpio_o_reg;
	logic [GPIO_PINS-1:0] gpio_oen_reg;
	logic [GPIO_PINS-1:0] gpio_in_reg;
	logic                 mclk_reg;

	// mode decode; the strap is read once after reset and then held,
	// so a glitch on it later cannot swap the protocol under the core
	always_comb
	begin
		mode_next = mode_reg;
		case (mode_reg)
			mode_wait:
			begin
				if (pins.ctrl_sel == SPI_SELECT_LEVEL) // R1
					mode_next = mode_spi;
				else if (pins.test_cs == TEST_ENTRY_LEVEL) // R3
					mode_next = mode_test;
				else
					mode_next = mode_i2c; // R1
			end
			mode_i2c:
			begin
				// a high shared pin in i2c mode forces test mode
				if (pins.test_cs == TEST_ENTRY_LEVEL) // R3
					mode_next = mode_test;
			end
			mode_test:
			begin
				// leaves test mode once the pin falls back low
				if (pins.test_cs != TEST_ENTRY_LEVEL)
					mode_next = mode_i2c;
			end
			mode_spi:
				mode_next = mode_spi; // R1
			default:
				mode_next = mode_wait;
		endcase
	end

	// mode register
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			mode_reg <= mode_wait;
		else
			mode_reg <= mode_next;
	end

	// mode flags toward the control core
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			spi_reg  <= 1'b0;
			test_reg <= 1'b0;
		end
		else
		begin
			spi_reg  <= (mode_next == mode_spi); // R1
			test_reg <= (mode_next == mode_test); // R3
		end
	end

	// control pins: chip select only means anything in spi mode
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			cs_reg     <= 1'b0;
			sck_reg    <= 1'b0;
			sdi_reg    <= 1'b0;
			sda_in_reg <= IDLE_HIGH;
		end
		else
		begin
			cs_reg  <= (mode_next == mode_spi)
				&& (pins.test_cs == CS_ACTIVE_LEVEL); // R2
			// clock pin is read in every mode, never driven
			sck_reg <= pins.ctrl_clk; // R6
			sdi_reg <= (mode_next == mode_spi) ? pins.ctrl_data : 1'b0; // R5
			sda_in_reg <= (mode_next == mode_i2c)
				? pins.ctrl_data : IDLE_HIGH; // R5
		end
	end

	// data pin driver: only ever pulls low, and only in i2c mode;
	// in spi mode and in test mode it is released as an input
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			data_oen_reg <= DRIVE_OFF;
		else
			data_oen_reg <= drive_oen((mode_next == mode_i2c)
				&& i_i2c_data_low); // R5
	end

	// interrupt and serial data out are push-pull, driven at all times;
	// no wired-or sharing of the interrupt line is possible
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			irq_reg     <= 1'b0;
			ser_out_reg <= 1'b0;
			ser_in_reg  <= 1'b0;
		end
		else
		begin
			irq_reg     <= i_irq_request; // R7
			ser_out_reg <= i_audio_serial_out;
			ser_in_reg  <= pins.audio_serial_in;
		end
	end

	// word select and bit clock direction follow the master setting
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			ws_o_reg     <= 1'b0;
			ws_oen_reg   <= DRIVE_OFF;
			bclk_o_reg   <= 1'b0;
			bclk_oen_reg <= DRIVE_OFF;
		end
		else
		begin
			ws_o_reg     <= i_ws_out;
			ws_oen_reg   <= drive_oen(i_audio_master); // R8
			bclk_o_reg   <= i_bclk_out;
			bclk_oen_reg <= drive_oen(i_audio_master); // R9
		end
	end

	// received audio clocks; zero while master so the core sees no echo
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			ws_in_reg   <= 1'b0;
			bclk_in_reg <= 1'b0;
		end
		else
		begin
			ws_in_reg   <= i_audio_master ? 1'b0 : pins.ws; // R8
			bclk_in_reg <= i_audio_master ? 1'b0 : pins.bclk; // R9
		end
	end

	// general-purpose pins, one direction bit each
	for (genvar g = 0; g < GPIO_PINS; g++)
	begin : g_gpio
		always_ff @(posedge i_clock)
		begin
			if (!i_rstn)
			begin
				gpio_o_reg[g]   <= 1'b0;
				gpio_oen_reg[g] <= DRIVE_OFF;
				gpio_in_reg[g]  <= 1'b0;
			end
			else
			begin
				gpio_o_reg[g]   <= i_gpio_out[g];
				gpio_oen_reg[g] <= drive_oen(i_gpio_dir_out[g]); // R10
				gpio_in_reg[g]  <= pins.gpio[g];
			end
		end
	end

	// master clock sampled; its frequency is the host's duty
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			mclk_reg <= 1'b0;
		else
			mclk_reg <= pins.mclk; // R11
	end

	// pin drivers
	assign pins.data_dev_o       = 1'b0;
	assign pins.data_dev_oen     = data_oen_reg;
	assign pins.irq              = irq_reg;
	assign pins.audio_serial_out = ser_out_reg;
	assign pins.ws_dev_o         = ws_o_reg;
	assign pins.ws_dev_oen       = ws_oen_reg;
	assign pins.bclk_dev_o       = bclk_o_reg;
	assign pins.bclk_dev_oen     = bclk_oen_reg;
	assign pins.gpio_dev_o       = gpio_o_reg;
	assign pins.gpio_dev_oen     = gpio_oen_reg;

	// core-side outputs
	assign o_ctrl_spi        = spi_reg;
	assign o_test_mode       = test_reg;
	assign o_spi_cs_active   = cs_reg;
	assign o_ctrl_sck        = sck_reg;
	assign o_ctrl_sdi        = sdi_reg;
	assign o_i2c_sda_in      = sda_in_reg;
	assign o_audio_serial_in = ser_in_reg;
	assign o_ws_in           = ws_in_reg;
	assign o_bclk_in         = bclk_in_reg;
	assign o_gpio_in         = gpio_in_reg;
	assign o_mclk_level      = mclk_reg;

endmodule

// ---- pin_select_host.sv ----
// host end: drives strap, control pins, audio clocks and master clock
`timescale 1ns/10ps
module pin_select_host
	import pin_select_pkg::*;
(
	// clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_rstn,
	// pins toward the device
	pin_select_if.host_end            pins,
	// control-port controller side
	input  wire logic                 i_select_spi,
	input  wire logic                 i_spi_cs_n,
	input  wire logic                 i_ctrl_clk,
	input  wire logic                 i_ctrl_data,
	input  wire logic                 i_i2c_data_low,
	output logic                      o_ctrl_data_in,
	output logic                      o_irq,
	// audio side
	input  wire logic                 i_device_master,
	input  wire logic                 i_ws_out,
	input  wire logic                 i_bclk_out,
	input  wire logic                 i_audio_serial_in,
	output logic                      o_audio_serial_out,
	output logic                      o_ws_in,
	output logic                      o_bclk_in,
	// general-purpose pins; host drives those the device reads
	input  wire logic [GPIO_PINS-1:0] i_gpio_dir_out,
	input  wire logic [GPIO_PINS-1:0] i_gpio_out,
	output logic      [GPIO_PINS-1:0] o_gpio_in
);

	localparam logic [MCLK_CNT_W-1:0] MCLK_LAST =
		MCLK_CNT_W'(MCLK_HALF_CYCLES - 1);

	logic                  started_reg;
	logic                  spi_reg;
	logic                  cs_reg;
	logic                  clk_reg;
	logic                  data_o_reg;
	logic                  data_oen_reg;
	logic                  ws_reg;
	logic                  bclk_reg;
	logic                  aud_oen_reg;
	logic                  ser_reg;
	logic [GPIO_PINS-1:0]  gpio_o_reg;
	logic [GPIO_PINS-1:0]  gpio_oen_reg;
	logic [MCLK_CNT_W-1:0] mclk_cnt_reg;
	logic                  mclk_reg;
	logic                  data_in_reg;
	logic                  irq_reg;
	logic                  ser_in_reg;
	logic                  ws_in_reg;
	logic                  bclk_in_reg;
	logic [GPIO_PINS-1:0]  gpio_in_reg;

	// strap already shown during reset: the device decides its mode at
	// the first edge out of reset, so a late strap would read as i2c
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			started_reg <= 1'b0;
			spi_reg     <= i_select_spi; // R12
		end
		else if (!started_reg)
		begin
			started_reg <= 1'b1;
			spi_reg     <= i_select_spi; // R12
		end
	end

	// shared pin: chip select in spi, held low in i2c to avoid test mode
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			cs_reg  <= 1'b0;
			clk_reg <= IDLE_HIGH;
		end
		else
		begin
			cs_reg  <= spi_reg ? i_spi_cs_n : 1'b0; // R4
			clk_reg <= i_ctrl_clk;
		end
	end

	// data pin: pushed in spi, pulled low only in i2c
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			data_o_reg   <= 1'b0;
			data_oen_reg <= DRIVE_OFF;
		end
		else if (spi_reg)
		begin
			data_o_reg   <= i_ctrl_data;
			data_oen_reg <= DRIVE_ON;
		end
		else
		begin
			data_o_reg   <= 1'b0;
			data_oen_reg <= drive_oen(i_i2c_data_low);
		end
	end

	// audio clocks driven only while the device is slave
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			ws_reg      <= 1'b0;
			bclk_reg    <= 1'b0;
			aud_oen_reg <= DRIVE_OFF;
			ser_reg     <= 1'b0;
		end
		else
		begin
			ws_reg      <= i_ws_out;
			bclk_reg    <= i_bclk_out;
			aud_oen_reg <= drive_oen(!i_device_master); // R8 R9
			ser_reg     <= i_audio_serial_in;
		end
	end

	// gpio: host drives a pin only while the device reads it
	for (genvar g = 0; g < GPIO_PINS; g++)
	begin : g_gpio
		always_ff @(posedge i_clock)
		begin
			if (!i_rstn)
			begin
				gpio_o_reg[g]   <= 1'b0;
				gpio_oen_reg[g] <= DRIVE_OFF;
			end
			else
			begin
				gpio_o_reg[g]   <= i_gpio_out[g];
				gpio_oen_reg[g] <= drive_oen(!i_gpio_dir_out[g]);
			end
		end
	end

	// master clock divider, held inside the accepted range
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			mclk_cnt_reg <= '0;
			mclk_reg     <= 1'b0;
		end
		else if (mclk_cnt_reg == MCLK_LAST)
		begin
			mclk_cnt_reg <= '0;
			mclk_reg     <= !mclk_reg; // R11
		end
		else
			mclk_cnt_reg <= mclk_cnt_reg + 1'b1;
	end

	// sampled pins toward the host logic
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			data_in_reg <= IDLE_HIGH;
			irq_reg     <= 1'b0;
			ser_in_reg  <= 1'b0;
			ws_in_reg   <= 1'b0;
			bclk_in_reg <= 1'b0;
			gpio_in_reg <= '0;
		end
		else
		begin
			data_in_reg <= pins.ctrl_data;
			irq_reg     <= pins.irq;
			ser_in_reg  <= pins.audio_serial_out;
			ws_in_reg   <= pins.ws;
			bclk_in_reg <= pins.bclk;
			gpio_in_reg <= pins.gpio;
		end
	end

	assign pins.ctrl_sel        = spi_reg;
	assign pins.test_cs         = cs_reg;
	assign pins.ctrl_clk        = clk_reg;
	assign pins.data_host_o     = data_o_reg;
	assign pins.data_host_oen   = data_oen_reg;
	assign pins.audio_serial_in = ser_reg;
	assign pins.ws_host_o       = ws_reg;
	assign pins.ws_host_oen     = aud_oen_reg;
	assign pins.bclk_host_o     = bclk_reg;
	assign pins.bclk_host_oen   = aud_oen_reg;
	assign pins.gpio_host_o     = gpio_o_reg;
	assign pins.gpio_host_oen   = gpio_oen_reg;
	assign pins.mclk            = mclk_reg;

	assign o_ctrl_data_in     = data_in_reg;
	assign o_irq              = irq_reg;
	assign o_audio_serial_out = ser_in_reg;
	assign o_ws_in            = ws_in_reg;
	assign o_bclk_in          = bclk_in_reg;
	assign o_gpio_in          = gpio_in_reg;

endmodule

// ---- pin_select_checker.sv ----
// concurrent checks on the pins between device and host ends
`timescale 1ns/10ps
module pin_select_checker
	import pin_select_pkg::*;
(
	// clock and reset
	input wire logic                 i_clock,
	input wire logic                 i_rstn,
	// control port pins
	input wire logic                 ctrl_sel,
	input wire logic                 test_cs,
	input wire logic                 data_dev_o,
	input wire logic                 data_dev_oen,
	// audio clock pins
	input wire logic                 ws_dev_o,
	input wire logic                 ws_dev_oen,
	input wire logic                 ws_host_oen,
	input wire logic                 ws,
	input wire logic                 bclk_dev_o,
	input wire logic                 bclk_dev_oen,
	input wire logic                 bclk_host_oen,
	input wire logic                 bclk,
	// general-purpose pins and master clock
	input wire logic [GPIO_PINS-1:0] gpio_dev_oen,
	input wire logic [GPIO_PINS-1:0] gpio_host_oen,
	input wire logic                 mclk
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);

	// divided master clock holds each level for two clocks
	sequence mclk_high_s;
		mclk [*2] ##1 !mclk;
	endsequence
	sequence mclk_low_s;
		!mclk [*2] ##1 mclk;
	endsequence

	// open drain: the device may only pull low
	data_open_drain_a: assert property (
		data_dev_oen == DRIVE_ON |-> !data_dev_o)
		else $error("data pin driven high by device");
	// spi strap makes the data pin an input only
	spi_data_input_a: assert property (
		data_dev_oen == DRIVE_ON |-> !ctrl_sel)
		else $error("data pin driven in spi mode");
	// shared pin kept low from the second clock that the strap asks for i2c
	test_pin_low_a: assert property (
		!ctrl_sel && $past(!ctrl_sel) |-> !test_cs)
		else $error("shared pin high in i2c mode");
	// no contention: only one end drives word select or bit clock
	ws_one_driver_a: assert property (
		ws_dev_oen == DRIVE_ON |-> ws_host_oen == DRIVE_OFF)
		else $error("word select driven by both ends");
	ws_follows_dev_a: assert property (
		ws_dev_oen == DRIVE_ON |-> ws == ws_dev_o)
		else $error("word select pin differs from device");
	bclk_one_driver_a: assert property (
		bclk_dev_oen == DRIVE_ON |-> bclk_host_oen == DRIVE_OFF)
		else $error("bit clock driven by both ends");
	bclk_follows_dev_a: assert property (
		bclk_dev_oen == DRIVE_ON |-> bclk == bclk_dev_o)
		else $error("bit clock pin differs from device");
	// a gpio pin never has both drivers on
	gpio_one_driver_a: assert property (
		(gpio_dev_oen | gpio_host_oen) == '1)
		else $error("gpio pin driven by both ends");
	mclk_high_a: assert property ($rose(mclk) |-> mclk_high_s)
		else $error("master clock high phase wrong");
	mclk_low_a: assert property ($fell(mclk) |-> mclk_low_s)
		else $error("master clock low phase wrong");
endmodule

// ---- control_port_pin_select_test.sv ----
// testbench joining device and host ends across the pin interface
`timescale 1ns/10ps
module control_port_pin_select_test;
	import pin_select_pkg::*;

	logic                 i_clock = 1'b0;
	logic                 i_rstn = 1'b0;
	int                   n_mismatch = 0;
	int                   n_checks = 0;
	// device user side
	logic                 dlow_d, irq_req, aso_d, master, ws_d, bclk_d;
	logic [GPIO_PINS-1:0] gdir, gout_d, gin_d;
	logic                 ctrl_spi, test_mode, cs_act, sck, sdi, sda_in;
	logic                 asi_d, ws_in_d, bclk_in_d, mclk_lvl;
	// host user side
	logic                 sel_spi, cs_n, clk_h, data_h, dlow_h;
	logic                 ws_h, bclk_h, asi_h;
	logic [GPIO_PINS-1:0] gout_h, gin_h;
	logic                 data_in_h, irq_h, aso_h, ws_in_h, bclk_in_h;
	int                   cnt;

	always #12.5 i_clock = ~i_clock;

	pin_select_if pins ();

	pin_select_device pin_select_device_inst (
		.i_clock(i_clock), .i_rstn(i_rstn), .pins(pins),
		.i_i2c_data_low(dlow_d), .o_ctrl_spi(ctrl_spi),
		.o_test_mode(test_mode), .o_spi_cs_active(cs_act),
		.o_ctrl_sck(sck), .o_ctrl_sdi(sdi), .o_i2c_sda_in(sda_in),
		.i_irq_request(irq_req), .i_audio_serial_out(aso_d),
		.o_audio_serial_in(asi_d), .i_audio_master(master),
		.i_ws_out(ws_d), .i_bclk_out(bclk_d), .o_ws_in(ws_in_d),
		.o_bclk_in(bclk_in_d), .i_gpio_dir_out(gdir),
		.i_gpio_out(gout_d), .o_gpio_in(gin_d), .o_mclk_level(mclk_lvl));

	pin_select_host pin_select_host_inst (
		.i_clock(i_clock), .i_rstn(i_rstn), .pins(pins),
		.i_select_spi(sel_spi), .i_spi_cs_n(cs_n), .i_ctrl_clk(clk_h),
		.i_ctrl_data(data_h), .i_i2c_data_low(dlow_h),
		.o_ctrl_data_in(data_in_h), .o_irq(irq_h),
		.i_device_master(master), .i_ws_out(ws_h), .i_bclk_out(bclk_h),
		.i_audio_serial_in(asi_h), .o_audio_serial_out(aso_h),
		.o_ws_in(ws_in_h), .o_bclk_in(bclk_in_h), .i_gpio_dir_out(gdir),
		.i_gpio_out(gout_h), .o_gpio_in(gin_h));

	pin_select_checker pin_select_checker_inst (
		.i_clock(i_clock), .i_rstn(i_rstn), .ctrl_sel(pins.ctrl_sel),
		.test_cs(pins.test_cs), .data_dev_o(pins.data_dev_o),
		.data_dev_oen(pins.data_dev_oen), .ws_dev_o(pins.ws_dev_o),
		.ws_dev_oen(pins.ws_dev_oen), .ws_host_oen(pins.ws_host_oen),
		.ws(pins.ws), .bclk_dev_o(pins.bclk_dev_o),
		.bclk_dev_oen(pins.bclk_dev_oen),
		.bclk_host_oen(pins.bclk_host_oen), .bclk(pins.bclk),
		.gpio_dev_oen(pins.gpio_dev_oen),
		.gpio_host_oen(pins.gpio_host_oen), .mclk(pins.mclk));

	// compare one value, report and count a mismatch
	task automatic check(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	// registered on both ends, so allow pin and output stages to land
	task automatic settle();
		repeat (4) @(negedge i_clock);
	endtask

	// reset with a fresh strap; the strap is only read once after reset
	task automatic do_reset(input logic spi);
		@(negedge i_clock);
		i_rstn = 1'b0;
		sel_spi = spi;
		repeat (20) @(negedge i_clock);
		i_rstn = 1'b1;
		repeat (6) @(negedge i_clock);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (5000) @(posedge i_clock);
		n_mismatch++;
		final_report();
	end

	initial
	begin
		{dlow_d, irq_req, aso_d, master, ws_d, bclk_d} = '0;
		{gdir, gout_d, gout_h, sel_spi, data_h, dlow_h} = '0;
		{ws_h, bclk_h, asi_h} = '0;
		{cs_n, clk_h} = 2'h3;
		do_reset(1'b1);
		check(2'(ctrl_spi), 2'h1);
		check(2'(test_mode), 2'h0);
		cs_n = 1'b0;
		settle();
		check(2'(cs_act), 2'h1);
		cs_n = 1'b1;
		settle();
		check(2'(cs_act), 2'h0);
		// device asks to pull data low, but spi must refuse it
		for (int i = 0; i < 2; i++)
		begin
			data_h = i[0];
			clk_h = i[0];
			dlow_d = 1'b1;
			settle();
			check(2'(sdi), 2'(i[0]));
			check(2'(sck), 2'(i[0]));
			check(2'(pins.data_dev_oen), 2'(DRIVE_OFF));
		end
		dlow_d = 1'b0;
		clk_h = 1'b1;
		$display("test spi done");

		cs_n = 1'b0;
		do_reset(1'b0);
		check(2'(ctrl_spi), 2'h0);
		check(2'(test_mode), 2'h0);
		check(2'(cs_act), 2'h0);
		check(2'(pins.test_cs), 2'h0);
		// wired-and data line seen from both ends
		for (int i = 0; i < 4; i++)
		begin
			{dlow_d, dlow_h} = i[1:0];
			clk_h = i[0];
			settle();
			check(2'(data_in_h), 2'(i == 0));
			check(2'(sda_in), 2'(i == 0));
			check(2'(sck), 2'(i[0]));
		end
		{dlow_d, dlow_h} = 2'h0;
		$display("test i2c done");

		// interrupt must reach both levels; serial data both ways
		for (int i = 0; i < 4; i++)
		begin
			irq_req = i[0];
			aso_d = i[1];
			asi_h = i[0] ^ i[1];
			settle();
			check(2'(irq_h), 2'(i[0]));
			check(2'(aso_h), 2'(i[1]));
			check(2'(asi_d), 2'(i[0] ^ i[1]));
		end
		$display("test irq and data done");

		// word select and bit clock in slave and master roles
		for (int i = 0; i < 8; i++)
		begin
			master = i[2];
			ws_d = i[0];
			bclk_d = i[1];
			ws_h = !i[0];
			bclk_h = i[0];
			settle();
			if (master)
			begin
				check(2'(ws_in_h), 2'(i[0]));
				check(2'(bclk_in_h), 2'(i[1]));
				check(2'(ws_in_d), 2'h0);
				check(2'(bclk_in_d), 2'h0);
			end
			else
			begin
				check(2'(ws_in_d), 2'(!i[0]));
				check(2'(bclk_in_d), 2'(i[0]));
			end
		end
		$display("test audio clocks done");

		// every direction setting with opposing data on each end
		for (int i = 0; i < 16; i++)
		begin
			gdir = i[1:0];
			gout_d = i[3:2];
			gout_h = ~i[3:2];
			settle();
			check(gin_h, (gdir & gout_d) | (~gdir & gout_h));
			check(gin_d, (gdir & gout_d) | (~gdir & gout_h));
		end
		$display("test gpio done");

		// two clocks per level gives twenty changes in forty cycles
		cnt = 0;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge i_clock);
			if (mclk_lvl !== pins.mclk)
				cnt++;
		end
		check(2'(cnt >= 15 && cnt <= 25), 2'h1);
		$display("test master clock done");
		final_report();
	end
endmodule
